// ==== cdi_pkg.sv ====
// shared constants and types for the coherent dma invalidate ends
package cdi_pkg;

    // =====================================================================
    // address capture window
    // =====================================================================
    localparam int AD_W = 32;
    localparam int WIN_MSB = 12;
    localparam int WIN_LSB = 4;
    localparam int LO_W = 2;
    localparam int WORD_W = WIN_MSB - WIN_LSB + 1 + LO_W;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic RST_GRANT_N = 1'h1;
    localparam logic RST_COH_EN = 1'h0;
    localparam logic [WORD_W-1:0] RST_WORD = 11'h000;

    // =====================================================================
    // state encodings
    // =====================================================================
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_FINISH,
        DEV_DRAIN,
        DEV_FLUSH,
        DEV_HELD
    } cdi_dev_state_t;

    typedef enum logic [2:0] {
        MST_IDLE,
        MST_REQ,
        MST_ADDR,
        MST_DATA,
        MST_END,
        MST_REL
    } cdi_mst_state_t;

endpackage : cdi_pkg

// ==== cdi_bus_if.sv ====
// shared bus between the processor end and the dma master end
interface cdi_bus_if;
    logic bus_request_n;
    logic coherent_request_n;
    logic bus_grant_n;
    logic ale;
    logic wr_n;
    logic ack_n;
    logic invalidate_request_n;
    logic [cdi_pkg::AD_W-1:0] ad;
    logic [cdi_pkg::LO_W-1:0] addr_lo;

    modport dev (
        input bus_request_n,
        input coherent_request_n,
        input ale,
        input wr_n,
        input ack_n,
        input invalidate_request_n,
        input ad,
        input addr_lo,
        output bus_grant_n
    );

    modport mst (
        output bus_request_n,
        output coherent_request_n,
        output ale,
        output wr_n,
        output ack_n,
        output invalidate_request_n,
        output ad,
        output addr_lo,
        input bus_grant_n
    );
endinterface : cdi_bus_if

// ==== cdi_device.sv ====
// processor end: coherent dma arbitration and data cache invalidation
// Summary of operation
// - coherent enable latched from mode pin at first edge after reset release
// - disabled: plain dma, coherency inputs ignored
// - coherency request sampled with bus request
// - master asserts coherency request with bus request
// - finish cycle, then drain read buffer
// - stall core, retire pending writes before grant
// - coherent grant only when stalled, drained, flushed
// - core stays stalled while coherent mastership held
// - master keeps coherency request stable throughout
// - ale with write loads address into counter
// - capture write address at ale trailing edge
// - invalidate sampled only on coherent write ack
// - invalidate word at current counter address
// - invalidate request asserted with write ack
// - every coherent write ack without ale increments counter after invalidation
// - burst: one address cycle, one ack per word
// - one invalidation per cycle, back to back
// - master negates write at end of each write
// - bus request negated: drop grant next edge
// - invalidations only on dma writes, never reads
module cdi_device (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // shared bus
    cdi_bus_if.dev bus,
    // mode strap, active low enable
    input wire logic coherent_dma_enable_mode_n,
    // processor core status
    input wire logic cycle_busy,
    input wire logic rbuf_pending,
    input wire logic wbuf_pending,
    // processor core control
    output logic core_stall,
    output logic rbuf_drain,
    output logic wbuf_retire,
    // data cache invalidation
    output logic dcache_inv_valid,
    output logic [cdi_pkg::WORD_W-1:0] dcache_inv_word,
    // status
    output logic coherent_enabled,
    output logic dma_held
);

    // =====================================================================
    // elaboration checks
    // =====================================================================
    // counter window must sit inside the address bus
    if (cdi_pkg::WIN_LSB > cdi_pkg::WIN_MSB || cdi_pkg::WIN_MSB >= cdi_pkg::AD_W) begin : g_win_chk
        $error("counter window outside the address bus");
    end
    // counter must hold exactly the window and the low address bits
    if (cdi_pkg::WORD_W != cdi_pkg::WIN_MSB - cdi_pkg::WIN_LSB + 1 + cdi_pkg::LO_W) begin : g_word_chk
        $error("counter width does not match its window");
    end

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        cdi_pkg::cdi_dev_state_t st;
        logic mode_seen;
        logic coh_en;
        logic coh_cycle;
        logic grant_n;
        logic stall;
        logic drain;
        logic retire;
        logic inv_v;
        logic [cdi_pkg::WORD_W-1:0] inv_word;
        logic [cdi_pkg::WORD_W-1:0] ctr;
    } cdi_dev_t;

    cdi_dev_t q;
    cdi_dev_t d;

    // =====================================================================
    // coherent write qualifiers
    // =====================================================================
    logic coh_write;
    logic word_ack;
    logic inv_take;

    // reads and non-coherent mastership never touch the counter
    assign coh_write = q.coh_en && q.coh_cycle && !bus.wr_n;
    assign word_ack = coh_write && !bus.ack_n;
    assign inv_take = word_ack && !bus.invalidate_request_n;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        d = q;
        d.drain = 1'b0;
        d.retire = 1'b0;
        d.inv_v = 1'b0;
        // first clocked edge after reset release catches the strap
        if (!q.mode_seen) begin
            d.mode_seen = 1'b1;
            d.coh_en = ~coherent_dma_enable_mode_n;
        end
        case (q.st)
            cdi_pkg::DEV_IDLE: begin
                if (!bus.bus_request_n && q.mode_seen) begin
                    // strap high means coherency inputs are ignored
                    d.coh_cycle = q.coh_en && !bus.coherent_request_n;
                    d.st = cdi_pkg::DEV_FINISH;
                end
            end
            cdi_pkg::DEV_FINISH: begin
                if (bus.bus_request_n) begin
                    d.coh_cycle = 1'b0;
                    d.st = cdi_pkg::DEV_IDLE;
                end else if (!cycle_busy) begin
                    if (q.coh_cycle) begin
                        d.st = cdi_pkg::DEV_DRAIN;
                    end else begin
                        d.grant_n = 1'b0;
                        d.st = cdi_pkg::DEV_HELD;
                    end
                end
            end
            cdi_pkg::DEV_DRAIN: begin
                // core keeps streaming while the read buffer empties
                if (bus.bus_request_n) begin
                    d.coh_cycle = 1'b0;
                    d.st = cdi_pkg::DEV_IDLE;
                end else if (rbuf_pending) begin
                    d.drain = 1'b1;
                end else begin
                    d.stall = 1'b1;
                    d.st = cdi_pkg::DEV_FLUSH;
                end
            end
            cdi_pkg::DEV_FLUSH: begin
                if (bus.bus_request_n) begin
                    d.stall = 1'b0;
                    d.coh_cycle = 1'b0;
                    d.st = cdi_pkg::DEV_IDLE;
                end else if (wbuf_pending) begin
                    d.retire = 1'b1;
                end else if (rbuf_pending) begin
                    d.drain = 1'b1;
                end else begin
                    d.grant_n = 1'b0;
                    d.st = cdi_pkg::DEV_HELD;
                end
            end
            cdi_pkg::DEV_HELD: begin
                if (bus.bus_request_n) begin
                    d.grant_n = 1'b1;
                    d.stall = 1'b0;
                    d.coh_cycle = 1'b0;
                    d.st = cdi_pkg::DEV_IDLE;
                end else if (coh_write) begin
                    d.stall = 1'b1;
                    if (bus.ale) begin
                        // reloaded every ale cycle, the last one holds at ale fall
                        d.ctr = {bus.ad[cdi_pkg::WIN_MSB:cdi_pkg::WIN_LSB], bus.addr_lo};
                    end else if (word_ack) begin
                        if (inv_take) begin
                            d.inv_v = 1'b1;
                            d.inv_word = q.ctr;
                        end
                        d.ctr = q.ctr + 11'h001;
                    end
                end
            end
            default: begin
                d.st = cdi_pkg::DEV_IDLE;
            end
        endcase
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q.st <= cdi_pkg::DEV_IDLE;
            q.mode_seen <= 1'b0;
            q.coh_en <= cdi_pkg::RST_COH_EN;
            q.coh_cycle <= 1'b0;
            q.grant_n <= cdi_pkg::RST_GRANT_N;
            q.stall <= 1'b0;
            q.drain <= 1'b0;
            q.retire <= 1'b0;
            q.inv_v <= 1'b0;
            q.inv_word <= cdi_pkg::RST_WORD;
            q.ctr <= cdi_pkg::RST_WORD;
        end else begin
            q <= d;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign bus.bus_grant_n = q.grant_n;
    assign core_stall = q.stall;
    assign rbuf_drain = q.drain;
    assign wbuf_retire = q.retire;
    assign dcache_inv_valid = q.inv_v;
    assign dcache_inv_word = q.inv_word;
    assign coherent_enabled = q.coh_en;
    assign dma_held = q.coh_cycle;

endmodule : cdi_device

// ==== cdi_dma_master.sv ====
// dma master and memory end: coherent burst writes with invalidation
module cdi_dma_master #(
    parameter int LEN_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // shared bus
    cdi_bus_if.mst bus,
    // user request
    input wire logic go,
    input wire logic go_coherent,
    input wire logic go_inval,
    input wire logic [cdi_pkg::WORD_W-1:0] go_word,
    input wire logic [LEN_W-1:0] go_len,
    // user status
    output logic busy,
    output logic done
);

    if (LEN_W < 1 || LEN_W > 16) begin : g_len_chk
        $error("LEN_W out of range");
    end

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        cdi_pkg::cdi_mst_state_t st;
        logic breq_n;
        logic coh_n;
        logic ale;
        logic wr_n;
        logic ack_n;
        logic ivd_n;
        logic [cdi_pkg::AD_W-1:0] ad;
        logic [cdi_pkg::LO_W-1:0] lo;
        logic [LEN_W-1:0] left;
        logic inval;
        logic busy;
        logic done;
    } cdi_mst_t;

    cdi_mst_t q;
    cdi_mst_t d;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            cdi_pkg::MST_IDLE: begin
                if (go && go_len != '0) begin
                    d.breq_n = 1'b0;
                    d.coh_n = ~go_coherent;
                    d.ad = '0;
                    d.ad[cdi_pkg::WIN_MSB:cdi_pkg::WIN_LSB] = go_word[cdi_pkg::WORD_W-1:cdi_pkg::LO_W];
                    d.lo = go_word[cdi_pkg::LO_W-1:0];
                    d.left = go_len;
                    d.inval = go_inval;
                    d.busy = 1'b1;
                    d.st = cdi_pkg::MST_REQ;
                end
            end
            cdi_pkg::MST_REQ: begin
                if (!bus.bus_grant_n) begin
                    d.ale = 1'b1;
                    d.wr_n = 1'b0;
                    d.st = cdi_pkg::MST_ADDR;
                end
            end
            cdi_pkg::MST_ADDR: begin
                d.ale = 1'b0;
                d.ack_n = 1'b0;
                d.ivd_n = ~q.inval;
                d.left = q.left - 1'b1;
                d.st = cdi_pkg::MST_DATA;
            end
            cdi_pkg::MST_DATA: begin
                if (q.left == '0) begin
                    d.ack_n = 1'b1;
                    d.ivd_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.st = cdi_pkg::MST_END;
                end else begin
                    d.left = q.left - 1'b1;
                end
            end
            cdi_pkg::MST_END: begin
                d.breq_n = 1'b1;
                d.coh_n = 1'b1;
                d.st = cdi_pkg::MST_REL;
            end
            cdi_pkg::MST_REL: begin
                if (bus.bus_grant_n) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.st = cdi_pkg::MST_IDLE;
                end
            end
            default: begin
                d.st = cdi_pkg::MST_IDLE;
            end
        endcase
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q.st <= cdi_pkg::MST_IDLE;
            q.breq_n <= 1'b1;
            q.coh_n <= 1'b1;
            q.ale <= 1'b0;
            q.wr_n <= 1'b1;
            q.ack_n <= 1'b1;
            q.ivd_n <= 1'b1;
            q.ad <= '0;
            q.lo <= '0;
            q.left <= '0;
            q.inval <= 1'b0;
            q.busy <= 1'b0;
            q.done <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign bus.bus_request_n = q.breq_n;
    assign bus.coherent_request_n = q.coh_n;
    assign bus.ale = q.ale;
    assign bus.wr_n = q.wr_n;
    assign bus.ack_n = q.ack_n;
    assign bus.invalidate_request_n = q.ivd_n;
    assign bus.ad = q.ad;
    assign bus.addr_lo = q.lo;
    assign busy = q.busy;
    assign done = q.done;

endmodule : cdi_dma_master

// ==== cdi_chk.sv ====
// concurrent checks on the shared coherent dma bus
module cdi_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // shared bus
    input wire logic bus_request_n,
    input wire logic coherent_request_n,
    input wire logic bus_grant_n,
    input wire logic ale,
    input wire logic wr_n,
    input wire logic ack_n,
    input wire logic invalidate_request_n,
    input wire logic [cdi_pkg::AD_W-1:0] ad,
    input wire logic [cdi_pkg::LO_W-1:0] addr_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ========
    // arbitration
    grant_cause_a: assert property ($fell(bus_grant_n) |-> !$past(bus_request_n) && !$past(bus_request_n,2))
        else $error("grant without held request");
    idle_nogrant_a: assert property (bus_grant_n && bus_request_n |=> bus_grant_n)
        else $error("grant while idle");
    grant_bound_a: assert property ($fell(bus_request_n) |-> ##[2:80] !bus_grant_n)
        else $error("grant never came");
    grant_release_a: assert property (!bus_grant_n && bus_request_n |=> bus_grant_n)
        else $error("grant kept after release");
    coh_pair_a: assert property ($fell(coherent_request_n) |-> $fell(bus_request_n))
        else $error("coherent request alone");
    coh_stable_a: assert property (!bus_request_n && !$past(bus_request_n) |-> $stable(coherent_request_n))
        else $error("coherent request moved");

    // ========
    // write transfers
    ivd_ack_a: assert property (!invalidate_request_n |-> !ack_n)
        else $error("invalidate without ack");
    ack_ctx_a: assert property (!ack_n |-> !bus_grant_n && !wr_n)
        else $error("ack outside granted write");
    ale_ack_a: assert property (ale |=> !ack_n && !ale)
        else $error("no ack after address");
    wr_end_a: assert property ($rose(ack_n) |-> $rose(wr_n))
        else $error("write kept after last ack");

    cover property ($fell(bus_grant_n) && !coherent_request_n);
    cover property (!ack_n && !invalidate_request_n);
    cover property (ale && addr_lo == 2'h2 && ad[12]);
    cover property (!ack_n ##1 !ack_n ##1 !ack_n);
endmodule : cdi_chk

// ==== tb_coherent_dma_invalidate.sv ====
// testbench joining the processor end and the dma master end
module tb_coherent_dma_invalidate;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk;
    logic rst;
    logic mode_n;
    logic cycle_busy;
    logic rbuf_pending;
    logic wbuf_pending;
    logic core_stall;
    logic rbuf_drain;
    logic wbuf_retire;
    logic inv_v;
    logic [10:0] inv_w;
    logic coh_en;
    logic held;
    logic go;
    logic go_coh;
    logic go_inv;
    logic [10:0] go_word;
    logic [7:0] go_len;
    logic busy;
    logic done;
    int cb_cnt = 0;
    int rb_cnt = 0;
    int wb_cnt = 0;
    int err_count = 0;
    int tests_run = 0;
    int ord_bad = 0;
    logic held_seen = 1'b0;
    logic [10:0] inv_q[$];

    cdi_bus_if bus ();
    cdi_device u_cdi_device (.mclk(mclk), .rst(rst), .bus(bus.dev), .coherent_dma_enable_mode_n(mode_n),
        .cycle_busy(cycle_busy), .rbuf_pending(rbuf_pending), .wbuf_pending(wbuf_pending),
        .core_stall(core_stall), .rbuf_drain(rbuf_drain), .wbuf_retire(wbuf_retire),
        .dcache_inv_valid(inv_v), .dcache_inv_word(inv_w), .coherent_enabled(coh_en), .dma_held(held));
    cdi_dma_master #(.LEN_W(8)) u_cdi_dma_master (.mclk(mclk), .rst(rst), .bus(bus.mst), .go(go),
        .go_coherent(go_coh), .go_inval(go_inv), .go_word(go_word), .go_len(go_len), .busy(busy), .done(done));
    cdi_chk u_cdi_chk (.mclk(mclk), .rst(rst), .bus_request_n(bus.bus_request_n),
        .coherent_request_n(bus.coherent_request_n), .bus_grant_n(bus.bus_grant_n), .ale(bus.ale),
        .wr_n(bus.wr_n), .ack_n(bus.ack_n), .invalidate_request_n(bus.invalidate_request_n),
        .ad(bus.ad), .addr_lo(bus.addr_lo));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ========
    // core model: cycle work counts down alone, buffer work shrinks as the device asks
    assign cycle_busy = cb_cnt != 0;
    assign rbuf_pending = rb_cnt != 0;
    assign wbuf_pending = wb_cnt != 0;
    always @(negedge mclk) begin
        if (cb_cnt > 0) cb_cnt <= cb_cnt - 1;
        if (rbuf_drain === 1'b1 && rb_cnt > 0) rb_cnt <= rb_cnt - 1;
        if (wbuf_retire === 1'b1 && wb_cnt > 0) wb_cnt <= wb_cnt - 1;
    end

    always @(posedge mclk) begin
        if (inv_v === 1'b1) inv_q.push_back(inv_w);
        if (held === 1'b1) held_seen = 1'b1;
        if (bus.bus_grant_n === 1'b0 && held === 1'b1 && core_stall !== 1'b1) ord_bad++;
        if (wbuf_retire === 1'b1 && rbuf_pending) ord_bad++;
        if (rbuf_drain === 1'b1 && cycle_busy) ord_bad++;
        if ($fell(bus.bus_grant_n) && (rb_cnt + wb_cnt + cb_cnt) != 0) ord_bad++;
    end

    // ========
    // tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask : chk

    task automatic chk_inv(input logic [10:0] w, input int n);
        chk("inv_count", n, inv_q.size());
        for (int i = 0; i < n && i < inv_q.size(); i++) chk("inv_word", 11'(w + i), inv_q[i]);
        inv_q = {};
    endtask : chk_inv

    task automatic do_reset(input logic m);
        @(negedge mclk);
        rst = 1'b1;
        mode_n = m;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : do_reset

    task automatic xfer(input logic c, input logic v, input logic [10:0] w, input logic [7:0] n);
        int k;
        @(negedge mclk);
        go = 1'b1;
        go_coh = c;
        go_inv = v;
        go_word = w;
        go_len = n;
        @(negedge mclk);
        go = 1'b0;
        chk("busy", 1, busy);
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        chk("done", 1, k < 300);
        chk("idle", 0, busy);
    endtask : xfer

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    initial begin
        #50000;
        err_count++;
        conclude();
    end

    // ========
    // tests
    initial begin
        rst = 1'b1;
        mode_n = 1'b0;
        go = 1'b0;
        go_coh = 1'b0;
        go_inv = 1'b0;
        go_word = 11'h000;
        go_len = 8'h00;
        do_reset(1'b0);
        chk("coh_en", 1, coh_en);
        mode_n = 1'b1;
        xfer(1'b1, 1'b1, 11'h7FE, 8'h04);
        chk_inv(11'h7FE, 4);
        chk("held_seen", 1, held_seen);
        $display("test burst wrap ended");
        cb_cnt = 8;
        rb_cnt = 4;
        wb_cnt = 5;
        xfer(1'b1, 1'b0, 11'h100, 8'h03);
        chk_inv(11'h000, 0);
        chk("stall_free", 0, core_stall);
        xfer(1'b1, 1'b1, 11'h005, 8'h01);
        chk_inv(11'h005, 1);
        chk("order", 0, ord_bad);
        chk("coh_en_kept", 1, coh_en);
        $display("test housekeeping ended");
        held_seen = 1'b0;
        xfer(1'b0, 1'b1, 11'h020, 8'h02);
        chk_inv(11'h000, 0);
        chk("held_seen", 0, held_seen);
        chk("held_clear", 0, held);
        $display("test plain dma ended");
        do_reset(1'b1);
        chk("coh_en", 0, coh_en);
        xfer(1'b1, 1'b1, 11'h040, 8'h03);
        chk_inv(11'h000, 0);
        chk("held_seen", 0, held_seen);
        $display("test disabled ended");
        conclude();
    end
endmodule : tb_coherent_dma_invalidate
